// file: common/acc_if.sv
// Link between the register core and the comparator synchroniser and edge detector
`timescale 1ns/1ns
interface acc_if;
	import acc_pkg::*;
	logic      raw;
	acc_mode_t mode;
	logic      level;
	logic      evt;
	logic      tgl;

	modport core (output raw, output mode, input level, input evt, input tgl);
	modport det  (input raw, input mode, output level, output evt, output tgl);
endinterface

// file: common/acc_map.svh
// Register offsets, field positions, reset values and timing counts of the comparator control
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_ADDR_W      5
`define ACC_OFF_MUXCTL  5'h00
`define ACC_OFF_CSR     5'h04
`define ACC_OFF_CHAN    5'h08
`define ACC_OFF_CONV    5'h0C
`define ACC_OFF_STAT    5'h10
`define ACC_OFF_MASK    5'h14

`define ACC_B_MUXEN     6
`define ACC_B_OFF       7
`define ACC_B_BG        6
`define ACC_B_OUT       5
`define ACC_B_FLAG      4
`define ACC_B_IE        3
`define ACC_B_CAP       2
`define ACC_B_MODE_HI   1
`define ACC_B_MODE_LO   0
`define ACC_B_CONVEN    7
`define ACC_ST_EVT      0
`define ACC_ST_TGL      1
`define ACC_ST_W        2

`define ACC_CHAN_W      3
`define ACC_RST_BYTE    8'h00
`define ACC_RST_CHAN    3'h0
`define ACC_RST_ST      2'h0
`define ACC_SYNC_STAGES 2

`endif

// file: common/acc_pkg.sv
// Types shared by the comparator control modules
package acc_pkg;

	typedef enum logic [1:0] {
		ACC_MODE_TOGGLE = 2'h0,
		ACC_MODE_RSVD   = 2'h1,
		ACC_MODE_FALL   = 2'h2,
		ACC_MODE_RISE   = 2'h3
	} acc_mode_t;

	typedef enum logic [1:0] {
		ACC_BUS_IDLE = 2'b01,
		ACC_BUS_ACK  = 2'b10
	} acc_bus_st_t;

endpackage

// file: logic/acc_edge.sv
// Synchroniser for the raw comparator result and interrupt edge detection
`timescale 1ns/1ns
`include "acc_map.svh"
module acc_edge
	import acc_pkg::*;
#(
	parameter int STAGES = `ACC_SYNC_STAGES
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Core side
	acc_if.det        cif
);

	logic [STAGES-1:0] stage_q;
	logic              prev_q;

	function automatic logic acc_hit(input acc_mode_t m, input logic p, input logic c);
		unique case (m)
			ACC_MODE_TOGGLE: acc_hit = p ^ c;
			ACC_MODE_RSVD:   acc_hit = 1'b0;
			ACC_MODE_FALL:   acc_hit = p & ~c;
			ACC_MODE_RISE:   acc_hit = ~p & c;
		endcase
	endfunction

	generate
		if (STAGES < 2) begin : g_bad
			$error("acc_edge needs at least two synchroniser stages");
		end
		for (genvar i = 0; i < STAGES; i++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst)
					stage_q[i] <= 1'b0;
				else if (i == 0)
					stage_q[i] <= cif.raw;
				else
					stage_q[i] <= stage_q[(i == 0) ? 0 : i-1];
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst)
			prev_q <= 1'b0;
		else
			prev_q <= stage_q[STAGES-1];
	end

	assign cif.level = stage_q[STAGES-1];
	assign cif.evt   = acc_hit(cif.mode, prev_q, stage_q[STAGES-1]);
	assign cif.tgl   = prev_q ^ stage_q[STAGES-1];

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_sync_delay: assert property ($past(rst, STAGES) == 1'b0 |->
		cif.level == $past(cif.raw, STAGES))
		else $error("synchronised output does not follow raw input");
	chk_edge_single: assert property (cif.evt |=> !cif.evt || cif.mode == ACC_MODE_TOGGLE
		|| $changed(cif.mode))
		else $error("one edge produced two event pulses");
	chk_rsvd_quiet: assert property (cif.mode == ACC_MODE_RSVD |-> !cif.evt)
		else $error("reserved mode produced an event");
	chk_rise_edge: assert property (cif.mode == ACC_MODE_RISE && $rose(cif.level) |-> cif.evt)
		else $error("rising edge missed");
endmodule

// file: logic/acc_top.sv
// Comparator control: input selection, output synchronisation, interrupt flag and bus registers
// Function
// - Synchronise comparator output, one to two cycles
// - Mux enable, converter off: channel drives negative
// - Mux enable clear: negative pin drives negative
// - Disable bit seven switches comparator off
// - Bandgap select replaces positive pin input
// - Selected output event sets interrupt flag
// - Request needs flag, enable, global enable
// - Vector execution clears interrupt flag
// - Writing one clears flag, zero keeps
// - Capture enable routes output to capture
// - Capture enable clear disconnects capture input
// - Mode 00 toggle, 01 none, 10 fall, 11 rise
// - Three-bit channel field picks one of eight
`timescale 1ns/1ns
`include "acc_map.svh"
module acc_top
	import acc_pkg::*;
#(
	parameter int ADDR_W = `ACC_ADDR_W,
	parameter int CHAN_W = `ACC_CHAN_W
) (
	// Clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              SYS_RST,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	output var  logic [31:0]       AVS_READDATA,
	output var  logic              AVS_WAITREQUEST,
	// Analog comparator
	input  wire logic              COMP_RAW,
	output var  logic              COMP_OFF,
	output var  logic              BANDGAP_SELECT,
	output var  logic              NEG_FROM_MUX,
	output var  logic [CHAN_W-1:0] NEG_CHANNEL,
	// Processor and timer
	input  wire logic              GLOBAL_IRQ_ENABLE,
	input  wire logic              VECTOR_ACK,
	output var  logic              COMP_IRQ,
	output var  logic              CAPTURE_INPUT,
	// Event interrupt
	output var  logic              IRQ
);

	generate
		if (ADDR_W < `ACC_ADDR_W || CHAN_W != `ACC_CHAN_W) begin : g_bad
			$error("acc_top needs ADDR_W >= 5 and a three-bit channel field");
		end
	endgenerate

	acc_if cif ();

	acc_bus_st_t           st_q;
	acc_bus_st_t           st_d;
	logic                  neg_input_mux_enable_q;
	logic                  converter_enable_q;
	logic                  comparator_off_q;
	logic                  bandgap_select_q;
	logic                  comparator_irq_flag_q;
	logic                  comparator_irq_flag_d;
	logic                  comparator_irq_enable_q;
	logic                  capture_route_enable_q;
	logic                  irq_mode_hi_q;
	logic                  irq_mode_lo_q;
	logic [CHAN_W-1:0]     channel_select_q;
	logic [`ACC_ST_W-1:0]  stat_q;
	logic [`ACC_ST_W-1:0]  stat_d;
	logic [`ACC_ST_W-1:0]  mask_q;
	logic                  wr_go;
	logic [7:0]            wbyte;
	logic [7:0]            rbyte;

	function automatic logic acc_sel(input logic [ADDR_W-1:0] a, input logic [4:0] off);
		acc_sel = (a == ADDR_W'(off));
	endfunction

	// Comparator synchroniser and edge detector
	assign cif.raw  = COMP_RAW;
	assign cif.mode = acc_mode_t'({irq_mode_hi_q, irq_mode_lo_q});

	acc_edge #(
		.STAGES (`ACC_SYNC_STAGES)
	) u_edge (
		.clk (REF_CLK),
		.rst (SYS_RST),
		.cif (cif)
	);

	// Bus handshake: one wait cycle, then a single acknowledge cycle
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ACC_BUS_IDLE: if (AVS_READ || AVS_WRITE) st_d = ACC_BUS_ACK;
			ACC_BUS_ACK:  st_d = ACC_BUS_IDLE;
			default:      st_d = ACC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			st_q            <= ACC_BUS_IDLE;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			st_q            <= st_d;
			AVS_WAITREQUEST <= (st_d != ACC_BUS_ACK);
		end
	end

	assign wr_go = (st_q == ACC_BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];
	assign wbyte = AVS_WRITEDATA[7:0];

	always_comb begin
		rbyte = 8'h00;
		if (acc_sel(AVS_ADDRESS, `ACC_OFF_MUXCTL))
			rbyte[`ACC_B_MUXEN] = neg_input_mux_enable_q;
		else if (acc_sel(AVS_ADDRESS, `ACC_OFF_CSR))
			rbyte = {comparator_off_q, bandgap_select_q, cif.level,
				comparator_irq_flag_q, comparator_irq_enable_q, capture_route_enable_q,
				irq_mode_hi_q, irq_mode_lo_q};
		else if (acc_sel(AVS_ADDRESS, `ACC_OFF_CHAN))
			rbyte[CHAN_W-1:0] = channel_select_q;
		else if (acc_sel(AVS_ADDRESS, `ACC_OFF_CONV))
			rbyte[`ACC_B_CONVEN] = converter_enable_q;
		else if (acc_sel(AVS_ADDRESS, `ACC_OFF_STAT))
			rbyte[`ACC_ST_W-1:0] = stat_q;
		else if (acc_sel(AVS_ADDRESS, `ACC_OFF_MASK))
			rbyte[`ACC_ST_W-1:0] = mask_q;
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST)
			AVS_READDATA <= 32'h0000_0000;
		else if (st_q == ACC_BUS_IDLE && AVS_READ)
			AVS_READDATA <= {24'h00_0000, rbyte};
	end

	// Control registers
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			neg_input_mux_enable_q <= 1'b0;
			converter_enable_q     <= 1'b0;
			channel_select_q       <= `ACC_RST_CHAN;
			mask_q                 <= `ACC_RST_ST;
		end else if (wr_go) begin
			if (acc_sel(AVS_ADDRESS, `ACC_OFF_MUXCTL))
				neg_input_mux_enable_q <= wbyte[`ACC_B_MUXEN];
			if (acc_sel(AVS_ADDRESS, `ACC_OFF_CONV))
				converter_enable_q <= wbyte[`ACC_B_CONVEN];
			if (acc_sel(AVS_ADDRESS, `ACC_OFF_CHAN))
				channel_select_q <= wbyte[CHAN_W-1:0];
			if (acc_sel(AVS_ADDRESS, `ACC_OFF_MASK))
				mask_q <= wbyte[`ACC_ST_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			comparator_off_q        <= 1'b0;
			bandgap_select_q        <= 1'b0;
			comparator_irq_enable_q <= 1'b0;
			capture_route_enable_q  <= 1'b0;
			irq_mode_hi_q           <= 1'b0;
			irq_mode_lo_q           <= 1'b0;
		end else if (wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_CSR)) begin
			comparator_off_q        <= wbyte[`ACC_B_OFF];
			bandgap_select_q        <= wbyte[`ACC_B_BG];
			comparator_irq_enable_q <= wbyte[`ACC_B_IE];
			capture_route_enable_q  <= wbyte[`ACC_B_CAP];
			irq_mode_hi_q           <= wbyte[`ACC_B_MODE_HI];
			irq_mode_lo_q           <= wbyte[`ACC_B_MODE_LO];
		end
	end

	// Interrupt flag: a new event wins over a clear in the same cycle
	always_comb begin
		comparator_irq_flag_d = comparator_irq_flag_q;
		if (VECTOR_ACK)
			comparator_irq_flag_d = 1'b0;
		if (wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_CSR) && wbyte[`ACC_B_FLAG])
			comparator_irq_flag_d = 1'b0;
		if (cif.evt)
			comparator_irq_flag_d = 1'b1;
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST)
			comparator_irq_flag_q <= 1'b0;
		else
			comparator_irq_flag_q <= comparator_irq_flag_d;
	end

	// Sticky event status, cleared by writing ones
	always_comb begin
		stat_d = stat_q;
		if (wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_STAT))
			stat_d = stat_q & ~wbyte[`ACC_ST_W-1:0];
		stat_d[`ACC_ST_EVT] = stat_d[`ACC_ST_EVT] | cif.evt;
		stat_d[`ACC_ST_TGL] = stat_d[`ACC_ST_TGL] | cif.tgl;
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST)
			stat_q <= `ACC_RST_ST;
		else
			stat_q <= stat_d;
	end

	// Registered outputs
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			COMP_OFF       <= 1'b0;
			BANDGAP_SELECT <= 1'b0;
			NEG_FROM_MUX   <= 1'b0;
			NEG_CHANNEL    <= `ACC_RST_CHAN;
		end else begin
			COMP_OFF       <= comparator_off_q;
			BANDGAP_SELECT <= bandgap_select_q;
			NEG_FROM_MUX   <= neg_input_mux_enable_q & ~converter_enable_q;
			NEG_CHANNEL    <= (neg_input_mux_enable_q & ~converter_enable_q) ?
				channel_select_q : `ACC_RST_CHAN;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			COMP_IRQ      <= 1'b0;
			CAPTURE_INPUT <= 1'b0;
			IRQ           <= 1'b0;
		end else begin
			COMP_IRQ      <= comparator_irq_flag_q & comparator_irq_enable_q
				& GLOBAL_IRQ_ENABLE;
			CAPTURE_INPUT <= capture_route_enable_q & cif.level;
			IRQ           <= |(stat_q & mask_q);
		end
	end

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	chk_flag_set: assert property (cif.evt |=> comparator_irq_flag_q)
		else $error("event did not set the interrupt flag");
	chk_irq_gate: assert property (COMP_IRQ |-> $past(comparator_irq_flag_q)
		&& $past(comparator_irq_enable_q) && $past(GLOBAL_IRQ_ENABLE))
		else $error("comparator request without flag and enables");
	chk_vector_clear: assert property (VECTOR_ACK && !cif.evt |=> !comparator_irq_flag_q)
		else $error("vector did not clear the flag");
	chk_w1c_flag: assert property (wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_CSR)
		&& !wbyte[`ACC_B_FLAG] && !VECTOR_ACK && comparator_irq_flag_q
		|=> comparator_irq_flag_q)
		else $error("writing zero changed the flag");
	chk_capture_off: assert property (!capture_route_enable_q |=> !CAPTURE_INPUT)
		else $error("capture input driven while route disabled");
	chk_capture_on: assert property (capture_route_enable_q && cif.level
		|=> CAPTURE_INPUT)
		else $error("capture input not driven by comparator");
	chk_neg_pin: assert property (!neg_input_mux_enable_q |=> !NEG_FROM_MUX
		&& NEG_CHANNEL == `ACC_RST_CHAN)
		else $error("negative input not on pin");
	chk_neg_mux: assert property (neg_input_mux_enable_q && !converter_enable_q
		|=> NEG_FROM_MUX && NEG_CHANNEL == $past(channel_select_q))
		else $error("negative input not taken from channel");
	chk_off_write: assert property (wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_CSR)
		|-> ##2 COMP_OFF == $past(wbyte[`ACC_B_OFF], 2))
		else $error("disable bit not applied");
	chk_bandgap: assert property (wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_CSR)
		|-> ##2 BANDGAP_SELECT == $past(wbyte[`ACC_B_BG], 2))
		else $error("bandgap select not applied");
	chk_bus_ack: assert property (st_q == ACC_BUS_IDLE && (AVS_READ || AVS_WRITE)
		|=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus acknowledge not a single cycle");

	// Interrupt, status, input-selection and read-data checks
	chk_conv_owns: assert property (converter_enable_q |=> !NEG_FROM_MUX
		&& NEG_CHANNEL == `ACC_RST_CHAN)
		else $error("negative input taken from channel while converter on");
	chk_irq_on: assert property (comparator_irq_flag_q && comparator_irq_enable_q
		&& GLOBAL_IRQ_ENABLE |=> COMP_IRQ)
		else $error("comparator request missing");
	chk_flag_hold: assert property (comparator_irq_flag_q && !VECTOR_ACK
		&& !(wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_CSR) && wbyte[`ACC_B_FLAG])
		|=> comparator_irq_flag_q)
		else $error("interrupt flag lost without a clear");
	chk_fall_edge: assert property (cif.mode == ACC_MODE_FALL
		&& $fell(cif.level) |-> cif.evt)
		else $error("falling edge missed");
	chk_toggle_edge: assert property (cif.mode == ACC_MODE_TOGGLE
		&& $changed(cif.level) |-> cif.evt)
		else $error("toggle missed");
	chk_stat_sticky: assert property (stat_q[`ACC_ST_EVT]
		&& !(wr_go && acc_sel(AVS_ADDRESS, `ACC_OFF_STAT) && wbyte[`ACC_ST_EVT])
		|=> stat_q[`ACC_ST_EVT])
		else $error("event status bit lost without a clear");
	chk_tgl_status: assert property (cif.tgl |=> stat_q[`ACC_ST_TGL])
		else $error("toggle did not set status");
	chk_irq_level: assert property ((|(stat_q & mask_q)) |=> IRQ)
		else $error("event interrupt not raised");
	chk_rdata_upper: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
`include "acc_map.svh"
module tb_top;
	import acc_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  be = 4'h0;
	logic [31:0] rdata;
	logic [31:0] scratch;
	logic        wait_r;
	logic        raw = 1'b0;
	logic        comp_off;
	logic        bg;
	logic        neg_mux;
	logic [2:0]  neg_ch;
	logic        glob_en = 1'b0;
	logic        vec_ack = 1'b0;
	logic        comp_irq;
	logic        cap_in;
	logic        irq;
	int          err_count = 0;
	int          n_checks = 0;
	// Behavioural model state
	logic [7:0]  csr_m = 8'h00;
	logic        flag_m = 1'b0;
	logic        out_m = 1'b0;
	logic [1:0]  st_m = 2'h0;
	logic [1:0]  mask_m = 2'h0;

	acc_top i_dut (
		.REF_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_r), .COMP_RAW(raw), .COMP_OFF(comp_off), .BANDGAP_SELECT(bg),
		.NEG_FROM_MUX(neg_mux), .NEG_CHANNEL(neg_ch), .GLOBAL_IRQ_ENABLE(glob_en),
		.VECTOR_ACK(vec_ack), .COMP_IRQ(comp_irq), .CAPTURE_INPUT(cap_in), .IRQ(irq)
	);

	always #25 clk = ~clk;

	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// One Avalon cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
			input logic b0, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'($urandom), d};
		be <= {3'($urandom), b0};
		do begin
			@(posedge clk);
			n++;
		end while (wait_r !== 1'b0 && n < 20);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (wait_r !== 1'b0) begin
			err_count++;
			close_out();
		end
	endtask

	task automatic wreg(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 1'b1, q);
	endtask

	task automatic chk_reg(input string name, input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, 1'b1, q);
		check(name, q, exp);
	endtask

	task automatic wcsr(input logic [7:0] v);
		wreg(`ACC_OFF_CSR, v);
		if (v[4])
			flag_m = 1'b0;
		csr_m = v & 8'hCF;
	endtask

	task automatic chk_all();
		chk_reg("csr", `ACC_OFF_CSR, {csr_m[7:6], out_m, flag_m, csr_m[3:0]});
		chk_reg("status", `ACC_OFF_STAT, {30'h0, st_m});
		check("irq", irq, |(st_m & mask_m));
		check("comp_irq", comp_irq, flag_m & csr_m[3] & glob_en);
		check("capture", cap_in, csr_m[2] & out_m);
		check("comp_off", comp_off, csr_m[7]);
		check("bandgap", bg, csr_m[6]);
	endtask

	// Move the raw result, let it settle, then predict events from the mode
	task automatic set_raw(input logic v);
		@(posedge clk);
		raw <= v;
		repeat (6) @(posedge clk);
		if (v !== out_m) begin
			st_m[1] = 1'b1;
			if (csr_m[1:0] == 2'h0 || csr_m[1:0] == {1'b1, v}) begin
				flag_m = 1'b1;
				st_m[0] = 1'b1;
			end
		end
		out_m = v;
		chk_all();
	endtask

	initial begin
		void'($urandom(32'h5384));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a <= 24; a += 4)
			chk_reg("reset", a[4:0], 32'h0);
		chk_all();
		// Negative input selection
		wreg(`ACC_OFF_MUXCTL, 8'h40);
		for (int c = 0; c < 8; c++) begin
			wreg(`ACC_OFF_CHAN, c[7:0]);
			repeat (2) @(posedge clk);
			check("neg_mux", neg_mux, 1'b1);
			check("neg_chan", neg_ch, c[2:0]);
		end
		chk_reg("chan", `ACC_OFF_CHAN, 32'h7);
		wreg(`ACC_OFF_CONV, 8'h80);
		repeat (2) @(posedge clk);
		check("neg_mux_conv", neg_mux, 1'b0);
		check("neg_chan_conv", neg_ch, 3'h0);
		chk_reg("conv", `ACC_OFF_CONV, 32'h80);
		wreg(`ACC_OFF_CONV, 8'h00);
		wreg(`ACC_OFF_MUXCTL, 8'h00);
		repeat (2) @(posedge clk);
		check("neg_mux_off", neg_mux, 1'b0);
		check("neg_chan_off", neg_ch, 3'h0);
		chk_reg("muxctl", `ACC_OFF_MUXCTL, 32'h0);
		// Disable and bandgap, then a write with byte lane 0 off
		wcsr({1'b1, 1'($urandom), 6'h00});
		chk_all();
		bus(1'b1, `ACC_OFF_CSR, 8'h00, 1'b0, scratch);
		chk_all();
		wcsr(8'h00);
		chk_all();
		// Every interrupt mode, rise then fall
		wreg(`ACC_OFF_MASK, 8'h01);
		mask_m = 2'h1;
		for (int m = 0; m < 4; m++) begin
			wcsr(m[7:0]);
			set_raw(1'b1);
			wcsr(m[7:0]);
			chk_all();
			set_raw(1'b0);
			wcsr(8'h10 | m[7:0]);
			chk_all();
			wreg(`ACC_OFF_STAT, 8'h03);
			st_m = 2'h0;
			chk_all();
		end
		// Request gating and vector clear
		@(posedge clk);
		glob_en <= 1'b1;
		wcsr(8'h0B);
		set_raw(1'b1);
		@(posedge clk);
		glob_en <= 1'b0;
		chk_all();
		@(posedge clk);
		glob_en <= 1'b1;
		chk_all();
		@(posedge clk);
		vec_ack <= 1'b1;
		@(posedge clk);
		vec_ack <= 1'b0;
		flag_m = 1'b0;
		chk_all();
		wcsr(8'h03);
		// Capture route with toggle events unmasked on status bit 1
		wreg(`ACC_OFF_MASK, 8'h02);
		mask_m = 2'h2;
		wcsr(8'h04);
		repeat (6) set_raw(1'($urandom));
		wcsr(8'h10);
		set_raw(~out_m);
		wreg(`ACC_OFF_STAT, 8'h03);
		st_m = 2'h0;
		chk_all();
		close_out();
	end
endmodule
